// ===== rtl/scsc_consts.svh
// Constants for the system clock switch control block
`ifndef SCSC_CONSTS_SVH
`define SCSC_CONSTS_SVH

// Register byte offsets
`define SCSC_OFS_CTRL        8'h00
`define SCSC_OFS_STAT        8'h04
`define SCSC_OFS_TCTRL       8'h08

// Control register fields
`define SCSC_CTRL_SCS_LSB    0
`define SCSC_CTRL_IFS_LSB    3

// Status register fields
`define SCSC_STAT_SUC        0
`define SCSC_STAT_T1RDY      1
`define SCSC_STAT_RUN_LSB    2
`define SCSC_STAT_BUSY       5
`define SCSC_STAT_SRC_LSB    6

// Timer control register fields
`define SCSC_TCTRL_EN        0

// Reset values
`define SCSC_RST_SCS         2'h0
`define SCSC_RST_IFS         4'h7

// Timing counts
`define SCSC_OST_COUNT       11'h400
`define SCSC_SYNC_EDGES      2'h2

// AXI responses
`define SCSC_RESP_OKAY       2'h0
`define SCSC_RESP_SLVERR     2'h2

`endif

// ===== rtl/scsc_pkg.sv
// Types for the system clock switch control block
package scsc_pkg;

  // Clock source codes, also the index into oscillator vectors
  typedef enum logic [2:0] {
    SRC_EXT = 3'h0,
    SRC_T1  = 3'h1,
    SRC_HF  = 3'h2,
    SRC_MF  = 3'h3,
    SRC_LF  = 3'h4
  } scsc_src_t;

  // Switch sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_WARM = 4'h2,
    ST_FALL = 4'h4,
    ST_HOLD = 4'h8
  } scsc_state_t;

  // Raw oscillator pins: clocks indexed by source, readies 1..4
  typedef struct packed {
    logic [4:1] rdy;
    logic [4:0] clk;
  } scsc_osc_pins_t;

  // Configuration word straps and companion enables
  typedef struct packed {
    logic [2:0] osc_mode;
    logic       two_speed_en;
    logic       watchdog_en;
    logic       failsafe_en;
  } scsc_cfg_t;

endpackage

// ===== rtl/scsc_top.sv
// System clock source selection and glitch-free switch sequencer
//
// Contract
// - Powered-down new oscillator started, delay awaited first
// - Wait old falling edge, hold low, new rise
// - Status shows running state of three oscillators
// - Same oscillator frequency change skips start-up delay
// - Select 00 uses configured primary source
// - Select 01 uses timer crystal oscillator
// - Select 1x uses internal block frequency
// - Reset clears clock source select
// - Automatic switches never alter source select
// - Startup flag set running external after timer
// - Startup flag ignores timer oscillator
// - Read-only timer oscillator ready flag, enable bit
// - Crystal modes count 1024 cycles before use
// - Two-speed runs internal clock while counting
// - Two-speed disabled outside crystal modes
// - Count done sets flag, moves to external
// - Sleep aborts count, flag stays clear
// - Low-frequency oscillator off unless watchdog/monitor; here also on while it is the current or target source
// - Reset loads frequency select with 0111
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "scsc_consts.svh"

module scsc_top (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // Oscillator pins and configuration
  input  wire scsc_pkg::scsc_osc_pins_t osc_pins,
  input  wire scsc_pkg::scsc_cfg_t     cfg,
  input  wire logic                    sleep_req,
  // Clock outputs
  output logic                         sys_clk_out,
  output logic [4:0]                   osc_enable,
  output logic [3:0]                   freq_select_active,
  // AXI4-Lite write address
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import scsc_pkg::*;

  // Oscillator owning a frequency select code
  function automatic scsc_src_t int_src(input logic [3:0] ifs);
    if (ifs[3:1] == 3'h0) begin
      int_src = SRC_LF;
    end else if (!ifs[3]) begin
      int_src = SRC_MF;
    end else begin
      int_src = SRC_HF;
    end
  endfunction

  // Synchronisers: three stages, level moves when stages 2 and 3 agree
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] sync3_r;
  logic [8:0] lvl_r;
  logic [8:0] lvl_nxt;
  logic [8:0] raw_in;

  assign raw_in = {osc_pins.rdy, osc_pins.clk};

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
      assign lvl_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi]
                                                          : lvl_r[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      sync3_r <= 9'h000;
      lvl_r   <= 9'h000;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lvl_r   <= lvl_nxt;
    end
  end

  // Edge pulses of the oscillator clocks, one system cycle each
  logic [4:0] clk_rise;
  logic [4:0] clk_fall;
  logic [4:0] clk_lvl;
  logic [4:0] rdy_lvl;

  assign clk_rise = lvl_nxt[4:0] & ~lvl_r[4:0];
  assign clk_fall = ~lvl_nxt[4:0] & lvl_r[4:0];
  assign clk_lvl  = lvl_r[4:0];
  assign rdy_lvl  = {lvl_r[8:5], 1'b0};

  // Software registers
  logic [1:0] scs_r;
  logic [3:0] ifs_r;
  logic       t1en_r;

  // Sequencer state
  scsc_state_t state_r;
  scsc_src_t   cur_r;
  scsc_src_t   tgt_r;
  logic [3:0]  ifs_act_r;
  logic [1:0]  hold_cnt_r;
  logic        sysclk_r;
  logic [4:0]  osc_en_r;
  logic [10:0] ost_cnt_r;
  logic        ost_done_r;

  // Mode decode
  logic crystal_mode;
  logic internal_oscillator_block_mode;
  logic two_speed;

  assign crystal_mode = (cfg.osc_mode < 3'h3);
  assign internal_oscillator_block_mode  = (cfg.osc_mode == 3'h4);
  assign two_speed    = crystal_mode && cfg.two_speed_en;

  // Wanted source; automatic two-speed choice never touches scs_r
  scsc_src_t want_src;
  scsc_src_t ifs_src;

  assign ifs_src = int_src(ifs_r);
  assign want_src =
      scs_r[1]              ? ifs_src :
      (scs_r == 2'h1)       ? SRC_T1 :
      internal_oscillator_block_mode           ? ifs_src :
      (two_speed && !ost_done_r) ? ifs_src :
      SRC_EXT;

  // A switch is needed on a new source or a new internal frequency
  logic need_switch;
  logic same_osc;

  assign same_osc    = (want_src == cur_r);
  assign need_switch = !same_osc ||
                       ((want_src != SRC_EXT) && (want_src != SRC_T1) &&
                        (ifs_r != ifs_act_r));

  // New oscillator usable; external crystal waits for the timer
  logic tgt_ready;

  assign tgt_ready =
      (tgt_r == SRC_EXT) ? (ost_done_r || !crystal_mode) :
      (osc_en_r[tgt_r] && rdy_lvl[tgt_r]);

  // Sequencer next state
  scsc_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (need_switch) begin
          // Same oscillator already running: no start-up wait
          state_nxt = same_osc ? ST_FALL : ST_WARM;
        end
      end
      ST_WARM: begin
        if (tgt_ready) begin
          state_nxt = ST_FALL;
        end
      end
      ST_FALL: begin
        if (clk_fall[cur_r]) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (clk_rise[tgt_r] && (hold_cnt_r == `SCSC_SYNC_EDGES - 2'h1)) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r    <= ST_RUN;
      cur_r      <= SRC_MF;
      tgt_r      <= SRC_MF;
      ifs_act_r  <= `SCSC_RST_IFS;
      hold_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_RUN) begin
        tgt_r <= want_src;
      end
      if (state_r == ST_HOLD && clk_rise[tgt_r]) begin
        hold_cnt_r <= hold_cnt_r + 2'h1;
      end else if (state_r != ST_HOLD) begin
        hold_cnt_r <= 2'h0;
      end
      if (state_r == ST_HOLD && state_nxt == ST_RUN) begin
        cur_r     <= tgt_r;
        ifs_act_r <= ifs_r;
      end
    end
  end

  // System clock: follows current source, low while handing over
  logic sysclk_nxt;

  assign sysclk_nxt =
      sleep_req                ? 1'b0 :
      (state_r == ST_HOLD)     ? 1'b0 :
      (state_r == ST_FALL)     ? (clk_lvl[cur_r] && !clk_fall[cur_r]) :
      clk_lvl[cur_r];

  // Oscillator enables; low-frequency one kept for watchdog or monitor
  logic [4:0] en_nxt;
  logic       lf_keep;

  assign lf_keep = cfg.watchdog_en || cfg.failsafe_en;

  generate
    for (gi = 1; gi < 5; gi = gi + 1) begin : g_en
      assign en_nxt[gi] = !sleep_req &&
                          ((cur_r == gi) || (tgt_r == gi) ||
                           ((gi == SRC_T1) && t1en_r));
    end
  endgenerate

  // External enable also while the start-up timer counts
  logic ext_en;

  assign ext_en    = !sleep_req && !internal_oscillator_block_mode;
  assign en_nxt[0] = ext_en;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sysclk_r <= 1'b0;
      osc_en_r <= 5'h00;
    end else begin
      sysclk_r <= sysclk_nxt;
      // Low oscillator dropped after leaving it unless still needed
      osc_en_r <= en_nxt | {lf_keep, 4'h0};
    end
  end

  // Start-up timer: counts crystal rising edges, sleep aborts it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ost_cnt_r  <= 11'h000;
      ost_done_r <= 1'b0;
    end else if (sleep_req || !crystal_mode) begin
      ost_cnt_r  <= 11'h000;
      ost_done_r <= 1'b0;
    end else if (!ost_done_r && clk_rise[SRC_EXT]) begin
      ost_cnt_r <= ost_cnt_r + 11'h001;
      if (ost_cnt_r == `SCSC_OST_COUNT - 11'h001) begin
        ost_done_r <= 1'b1;
      end
    end
  end

  // Status: startup flag only for external crystal, timer osc excluded
  logic       startup_complete_flag;
  logic       timer_osc_ready_flag;
  logic [2:0] int_running;

  assign startup_complete_flag = crystal_mode && ost_done_r &&
                                 (cur_r == SRC_EXT);
  assign timer_osc_ready_flag  = t1en_r && osc_en_r[SRC_T1] &&
                                 rdy_lvl[SRC_T1];
  assign int_running = osc_en_r[4:2] & rdy_lvl[4:2];

  // Register read values
  logic [31:0] ctrl_val;
  logic [31:0] stat_val;
  logic [31:0] tctrl_val;

  assign ctrl_val  = {25'h0, ifs_r, 1'b0, scs_r};
  assign stat_val  = {23'h0, cur_r, state_r != ST_RUN,
                      int_running, timer_osc_ready_flag,
                      startup_complete_flag};
  assign tctrl_val = {31'h0, t1en_r};

  // AXI write path: address and data taken in either order
  logic        aw_full_r;
  logic        w_full_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        do_write;
  logic        wr_ctrl;
  logic        wr_tctrl;
  logic        wr_hit;

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready  = !w_full_r && !bvalid_r;
  assign do_write      = aw_full_r && w_full_r && !bvalid_r;
  assign wr_ctrl       = do_write && (awaddr_r == `SCSC_OFS_CTRL);
  assign wr_tctrl      = do_write && (awaddr_r == `SCSC_OFS_TCTRL);
  // Status is read-only, so a write there still answers OKAY
  assign wr_hit        = (awaddr_r == `SCSC_OFS_CTRL) ||
                         (awaddr_r == `SCSC_OFS_STAT) ||
                         (awaddr_r == `SCSC_OFS_TCTRL);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `SCSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? `SCSC_RESP_OKAY : `SCSC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Software fields; every field sits in byte lane 0
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scs_r  <= `SCSC_RST_SCS;
      ifs_r  <= `SCSC_RST_IFS;
      t1en_r <= 1'b0;
    end else begin
      if (wr_ctrl && wstrb_r[0]) begin
        scs_r <= wdata_r[`SCSC_CTRL_SCS_LSB +: 2];
        ifs_r <= wdata_r[`SCSC_CTRL_IFS_LSB +: 4];
      end
      if (wr_tctrl && wstrb_r[0]) begin
        t1en_r <= wdata_r[`SCSC_TCTRL_EN];
      end
    end
  end

  // AXI read path: one read in flight, data one cycle after address
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign s_axi_arready = !rvalid_r;
  assign rd_hit = (s_axi_araddr == `SCSC_OFS_CTRL) ||
                  (s_axi_araddr == `SCSC_OFS_STAT) ||
                  (s_axi_araddr == `SCSC_OFS_TCTRL);
  assign rd_val =
      (s_axi_araddr == `SCSC_OFS_CTRL) ? ctrl_val :
      (s_axi_araddr == `SCSC_OFS_STAT) ? stat_val :
      (s_axi_araddr == `SCSC_OFS_TCTRL) ? tctrl_val :
      32'h0000_0000;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `SCSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? `SCSC_RESP_OKAY : `SCSC_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Outputs
  assign sys_clk_out        = sysclk_r;
  assign osc_enable         = osc_en_r;
  assign freq_select_active = ifs_act_r;
  assign s_axi_bvalid       = bvalid_r;
  assign s_axi_bresp        = bresp_r;
  assign s_axi_rvalid       = rvalid_r;
  assign s_axi_rdata        = rdata_r;
  assign s_axi_rresp        = rresp_r;

endmodule

// ===== bench/scsc_chk.sv
// Port-level assertions for the clock switch control block
`timescale 1ns/100ps

module scsc_chk (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 reset,
  // Clock side
  input wire scsc_pkg::scsc_cfg_t  cfg,
  input wire logic                 sleep_req,
  input wire logic                 sys_clk_out,
  input wire logic [4:0]           osc_enable,
  input wire logic [3:0]           freq_select_active,
  // Register bus handshakes
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready
);
  import scsc_pkg::*;

  // Single domain, so one clock and one disable for all
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // No runt pulses: oscillator halves outlast three cycles
  clk_high_a: assert property (
    $rose(sys_clk_out) |=> (sys_clk_out || sleep_req)[*3])
    else $error("short high pulse on system clock");
  clk_low_a: assert property (
    $fell(sys_clk_out) |=> (!sys_clk_out)[*3])
    else $error("short low pulse on system clock");
  lf_keep_a: assert property (
    (cfg.watchdog_en || cfg.failsafe_en)[*3] |-> osc_enable[4])
    else $error("low oscillator off while still needed");
  rst_freq_a: assert property (
    $fell(reset) |-> freq_select_active == 4'h7)
    else $error("frequency select not default after reset");
  // Sleep stops the clock and every oscillator but the low one
  sleep_gate_a: assert property (
    sleep_req[*3] |-> !sys_clk_out && osc_enable[3:0] == 4'h0)
    else $error("clock or oscillator running in sleep");
  w_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) // Held words first, response the edge after
    else $error("write response late");
  r_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
endmodule

bind scsc_top scsc_chk scsc_chk_inst (
  .clk_sys(clk_sys), .reset(reset), .cfg(cfg), .sleep_req(sleep_req),
  .sys_clk_out(sys_clk_out), .osc_enable(osc_enable),
  .freq_select_active(freq_select_active),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ===== bench/scsc_osc_model.sv
// Behavioural oscillator sources facing the clock switch block
`timescale 1ns/100ps

module scsc_osc_model (
  // Enables from the block
  input  wire logic [4:0]           osc_enable,
  // Clock levels and ready flags
  output scsc_pkg::scsc_osc_pins_t  osc_pins
);
  import scsc_pkg::*;

  // Half periods ext, timer, hf, mf, lf: all slower than clk_sys/8
  localparam int HALF_NS [5] = '{40, 60, 30, 50, 80};
  wire [4:0] clk_w;
  wire [4:0] rdy_w;

  assign osc_pins = '{rdy: rdy_w[4:1], clk: clk_w};

  // Disabled clocks stand still low; ready lags by a warm-up
  for (genvar i = 0; i < 5; i++) begin : g_osc
    logic c = 1'h0;
    logic r = 1'h0;
    initial forever begin
      #(HALF_NS[i]);
      c = osc_enable[i] ? ~c : 1'h0;
    end
    always @(osc_enable[i]) r <= #1000 osc_enable[i];
    assign clk_w[i] = c;
    assign rdy_w[i] = r;
  end
endmodule

// ===== bench/system_clock_switch_control_tb.sv
// Self-checking bench for the clock switch control block
`timescale 1ns/100ps

module system_clock_switch_control_tb;
  import scsc_pkg::*;

  logic           clk_sys = 1'h0;
  logic           reset = 1'h1;
  scsc_osc_pins_t osc_pins;
  scsc_cfg_t      cfg = '{3'h0, 1'h1, 1'h0, 1'h0};
  logic           sleep_req = 1'h0;
  logic           sys_clk_out;
  logic [4:0]     osc_enable;
  logic [3:0]     freq_select_active;
  logic [7:0]     s_axi_awaddr = 8'h00;
  logic [7:0]     s_axi_araddr = 8'h00;
  logic [31:0]    s_axi_wdata = 32'h0;
  logic [31:0]    s_axi_rdata;
  logic [31:0]    rd;
  logic           s_axi_awvalid = 1'h0;
  logic           s_axi_wvalid = 1'h0;
  logic           s_axi_bready = 1'h0;
  logic           s_axi_arvalid = 1'h0;
  logic           s_axi_rready = 1'h0;
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic           s_axi_arready, s_axi_rvalid;
  logic [1:0]     s_axi_bresp, s_axi_rresp, resp;
  int             n_errors = 0;
  int             checks = 0;
  int             cyc = 0;
  int             t0;

  scsc_top scsc_top_inst (
    .clk_sys(clk_sys), .reset(reset), .osc_pins(osc_pins), .cfg(cfg),
    .sleep_req(sleep_req), .sys_clk_out(sys_clk_out),
    .osc_enable(osc_enable), .freq_select_active(freq_select_active),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  scsc_osc_model scsc_osc_model_inst (
    .osc_enable(osc_enable),
    .osc_pins(osc_pins)
  );

  // 200 MHz system clock
  initial forever #2.5 clk_sys = ~clk_sys;

  // Hang guard: the crystal counts dominate the run time
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rst();
    reset <= 1'h1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge clk_sys);
    s_axi_bready <= 1'h1;
    @(posedge clk_sys);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  // Read: rready comes late on purpose so rdata must stand
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_arvalid);
    while (!s_axi_rvalid) @(posedge clk_sys);
    s_axi_rready <= 1'h1;
    @(posedge clk_sys);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Status polled until the masked field matches or reads run out
  task automatic poll(input logic [31:0] m, input logic [31:0] v,
                      input int n);
    do begin
      rdr(8'h04);
      n--;
    end while ((rd & m) !== v && n > 0);
    check(rd & m, v);
  endtask

  initial begin
    rst();
    rdr(8'h00); check(rd, 32'h38);
    rdr(8'h08); check(rd, 32'h0);
    check(freq_select_active, 4'h7);
    // Crystal counting while code runs on the internal clock
    poll(32'h1c1, 32'hc0, 20);
    repeat (8000) @(posedge clk_sys);
    sleep_req <= 1'h1;
    repeat (20) @(posedge clk_sys);
    check(sys_clk_out, 1'h0);
    sleep_req <= 1'h0;
    t0 = cyc;
    poll(32'h1c1, 32'hc0, 20);
    poll(32'h1c1, 32'h1, 8000);
    check(cyc - t0 >= 16360, 1'h1);
    rdr(8'h00); check(rd, 32'h38);
    // High internal frequency, then a step on the same oscillator
    wr(8'h00, 32'h42);
    poll(32'h1c0, 32'h80, 200);
    check(rd & 32'h5, 32'h4);
    check(freq_select_active, 4'h8);
    check(osc_enable[2], 1'h1);
    wr(8'h00, 32'h4a);
    t0 = cyc;
    while (freq_select_active !== 4'h9 && cyc - t0 < 100)
      @(posedge clk_sys);
    check(freq_select_active, 4'h9);
    // Low oscillator and back; it must be released afterwards
    wr(8'h00, 32'h02);
    poll(32'h1c0, 32'h100, 200);
    wr(8'h00, 32'h3a);
    poll(32'h1c0, 32'hc0, 200);
    repeat (4) @(posedge clk_sys);
    check(osc_enable[4], 1'h0);
    // Timer oscillator: firmware waits for ready before selecting
    wr(8'h08, 32'h1);
    rdr(8'h08); check(rd, 32'h1);
    poll(32'h2, 32'h2, 400);
    wr(8'h00, 32'h39);
    poll(32'h1c0, 32'h40, 200);
    // Read-only status, unmapped places
    wr(8'h04, 32'h0); check(resp, 2'h0);
    wr(8'h0c, 32'h0); check(resp, 2'h2);
    rdr(8'h0c); check(resp, 2'h2);
    cfg.watchdog_en <= 1'h1;
    repeat (5) @(posedge clk_sys);
    check(osc_enable[4], 1'h1);
    // Mid-run reset into external clock mode: no start-up count
    cfg <= '{3'h7, 1'h1, 1'h0, 1'h0};
    rst();
    rdr(8'h00); check(rd, 32'h38);
    poll(32'h1c0, 32'h0, 50);
    summarize();
  end
endmodule
